// ### common/cktm_regs.vh
// cktm_regs.vh - register map, field positions, reset values and timing
// counts of the clock timer.
// assumes: included by bare name from every design file of the block but the synchroniser.
`ifndef CKTM_REGS_VH
`define CKTM_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CKTM_ADDR_W          16
`define CKTM_OFS_CTRL        16'hFF78
`define CKTM_OFS_CNT_LO      16'hFF79
`define CKTM_OFS_CNT_HI      16'hFF7A
`define CKTM_OFS_IRQ_EN      16'hFFE6
`define CKTM_OFS_IRQ_FLAGS   16'hFFF6

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define CKTM_DATA_W          4
`define CKTM_CTRL_RUN_BIT    0
`define CKTM_CTRL_CLR_BIT    1
`define CKTM_TAP_32HZ_BIT    2
`define CKTM_TAP_8HZ_BIT     4
`define CKTM_TAP_2HZ_BIT     6
`define CKTM_TAP_1HZ_BIT     7
`define CKTM_NIBBLE_MAX      4'hF

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CKTM_RST_RUN         1'h0
`define CKTM_RST_NIBBLE      4'h0
`define CKTM_RST_IRQ_EN      4'h0
`define CKTM_RST_IRQ_FLAGS   4'h0
`define CKTM_RDATA_ZERO      4'h0

// ----------------------------------------------------------------------
// timing: 125 MHz clock, high word hold window least time
// ----------------------------------------------------------------------
`define CKTM_CLK_PERIOD_NS   8
`define CKTM_HOLD_MIN_NS     480000
// hold length in clocks: least hold time over the clock period, 60000
`define CKTM_HOLD_CYC        17'hEA60
`define CKTM_HOLD_CNT_W      17

`endif

// ### verilog/cktm_sync.v
// cktm_sync.v - two flip-flop synchroniser for one level.
// assumes: input may change at any time relative to clk_i.
module cktm_sync (
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire ce_i,
  input  wire d_i,
  output wire q_o
);

  reg meta_ff;
  reg sync_ff;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'h0;
      sync_ff <= 1'h0;
    end else if (ce_i) begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule

// ### verilog/cktm_flags.v
// cktm_flags.v - falling edge detect of the four interrupt taps and the
// sticky, write-one-to-clear flag register.
// assumes: tap values of the count before and after each clock edge.
`include "cktm_regs.vh"

module cktm_flags (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       ce_i,
  input  wire [7:0] cnt_now_i,
  input  wire [7:0] cnt_nxt_i,
  input  wire       edge_ok_i,
  input  wire       clr_wr_i,
  input  wire [3:0] clr_mask_i,
  output wire [3:0] flags_o
);

  reg  [3:0] flags_ff;
  wire [3:0] tap_now;
  wire [3:0] tap_nxt;
  wire [3:0] fall;
  wire [3:0] clr;

  assign tap_now = {cnt_now_i[`CKTM_TAP_1HZ_BIT], cnt_now_i[`CKTM_TAP_2HZ_BIT],
                    cnt_now_i[`CKTM_TAP_8HZ_BIT], cnt_now_i[`CKTM_TAP_32HZ_BIT]};
  assign tap_nxt = {cnt_nxt_i[`CKTM_TAP_1HZ_BIT], cnt_nxt_i[`CKTM_TAP_2HZ_BIT],
                    cnt_nxt_i[`CKTM_TAP_8HZ_BIT], cnt_nxt_i[`CKTM_TAP_32HZ_BIT]};

  assign fall = tap_now & ~tap_nxt & {4{edge_ok_i}};
  assign clr  = clr_mask_i & {4{clr_wr_i}};

  // set wins over a clear in the same cycle; mask plays no part here
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_ff <= `CKTM_RST_IRQ_FLAGS;
    end else if (ce_i) begin
      flags_ff <= (flags_ff & ~clr) | fall;
    end
  end

  assign flags_o = flags_ff;

endmodule

// ### verilog/cktm_top.v
// cktm_top.v - clock timer: 8-bit tick counter read as two nibbles with a
// high word hold, run/stop and clear control, four tap interrupts.
// assumes: a 256 Hz prescaler level from the low speed oscillator domain,
// a processor register port on clk_i, one cycle strobes.
//
// Design decision made here: the strobed register port.
`include "cktm_regs.vh"

module cktm_top #(
  parameter [`CKTM_HOLD_CNT_W-1:0] HOLD_CYC = `CKTM_HOLD_CYC
) (
  input  wire                    clk_i,
  input  wire                    nrst_i,
  input  wire                    ce_i,
  input  wire                    lso_prescale_i,
  input  wire [`CKTM_ADDR_W-1:0] addr_i,
  input  wire [`CKTM_DATA_W-1:0] wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output wire [`CKTM_DATA_W-1:0] rdata_o,
  output wire [7:0]              tick_count_bits_o,
  output wire                    irq_o
);

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function hit;
    input [`CKTM_ADDR_W-1:0] a;
    input [`CKTM_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  reg rst_meta_ff;
  reg rst_sync_ff;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_ff <= 1'h0;
      rst_sync_ff <= 1'h0;
    end else begin
      rst_meta_ff <= 1'h1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wire rst_n;
  assign rst_n = rst_sync_ff;

  // ----------------------------------------------------------------------
  // prescaler input: synchronise, then rising edge steps the counter
  // ----------------------------------------------------------------------
  wire presc_sync;
  reg  presc_prev_ff;

  cktm_sync u_presc_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .d_i     (lso_prescale_i),
    .q_o     (presc_sync)
  );

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      presc_prev_ff <= 1'h0;
    end else if (ce_i) begin
      presc_prev_ff <= presc_sync;
    end
  end

  // ----------------------------------------------------------------------
  // register strobes
  // ----------------------------------------------------------------------
  wire wr_ctrl;
  wire wr_en;
  wire wr_flags;
  wire rd_lo;
  wire rd_hi;

  assign wr_ctrl  = wr_i & hit(addr_i, `CKTM_OFS_CTRL);
  assign wr_en    = wr_i & hit(addr_i, `CKTM_OFS_IRQ_EN);
  assign wr_flags = wr_i & hit(addr_i, `CKTM_OFS_IRQ_FLAGS);
  assign rd_lo    = rd_i & hit(addr_i, `CKTM_OFS_CNT_LO);
  assign rd_hi    = rd_i & hit(addr_i, `CKTM_OFS_CNT_HI);

  // ----------------------------------------------------------------------
  // run control and mask register
  // ----------------------------------------------------------------------
  reg       count_run_control_ff;
  reg [3:0] tick_enable_ff;
  wire      count_clear_strobe;

  assign count_clear_strobe = wr_ctrl & wdata_i[`CKTM_CTRL_CLR_BIT];

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      count_run_control_ff <= `CKTM_RST_RUN;
      tick_enable_ff       <= `CKTM_RST_IRQ_EN;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        count_run_control_ff <= wdata_i[`CKTM_CTRL_RUN_BIT];
      end
      if (wr_en) begin
        tick_enable_ff <= wdata_i;
      end
    end
  end

  wire adv;
  assign adv = count_run_control_ff & presc_sync & ~presc_prev_ff;

  // ----------------------------------------------------------------------
  // tick counter with high nibble hold
  // ----------------------------------------------------------------------
  reg  [3:0]                 cnt_lo_ff;
  reg  [3:0]                 cnt_hi_ff;
  reg                        hold_ff;
  reg                        pend_ff;
  reg  [`CKTM_HOLD_CNT_W-1:0] hold_cnt_ff;

  reg  [3:0]                 nxt_cnt_lo;
  reg  [3:0]                 nxt_cnt_hi;
  reg                        nxt_hold;
  reg                        nxt_pend;
  reg  [`CKTM_HOLD_CNT_W-1:0] nxt_hold_cnt;

  wire                       lo_carry;
  wire                       hold_timeout;

  assign lo_carry     = adv & (cnt_lo_ff == `CKTM_NIBBLE_MAX);
  assign hold_timeout = hold_ff & (hold_cnt_ff >= HOLD_CYC - 1'b1);

  always @* begin
    nxt_cnt_lo   = cnt_lo_ff;
    nxt_cnt_hi   = cnt_hi_ff;
    nxt_hold     = hold_ff;
    nxt_pend     = pend_ff;
    nxt_hold_cnt = hold_cnt_ff;
    if (count_clear_strobe) begin
      // zeroed count; the run bit alone decides whether it moves on
      nxt_cnt_lo   = `CKTM_RST_NIBBLE;
      nxt_cnt_hi   = `CKTM_RST_NIBBLE;
      nxt_hold     = 1'h0;
      nxt_pend     = 1'h0;
      nxt_hold_cnt = {`CKTM_HOLD_CNT_W{1'b0}};
    end else begin
      nxt_cnt_lo = cnt_lo_ff + {3'h0, adv};
      if (rd_lo) begin
        nxt_hold     = 1'h1;
        nxt_hold_cnt = {`CKTM_HOLD_CNT_W{1'b0}};
      end else if (hold_ff & (rd_hi | hold_timeout)) begin
        nxt_hold     = 1'h0;
        nxt_hold_cnt = {`CKTM_HOLD_CNT_W{1'b0}};
      end else if (hold_ff) begin
        nxt_hold_cnt = hold_cnt_ff + 1'b1;
      end
      if (nxt_hold) begin
        nxt_pend = pend_ff | lo_carry;
      end else begin
        nxt_cnt_hi = cnt_hi_ff + {3'h0, lo_carry} + {3'h0, pend_ff};
        nxt_pend   = 1'h0;
      end
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_lo_ff   <= `CKTM_RST_NIBBLE;
      cnt_hi_ff   <= `CKTM_RST_NIBBLE;
      hold_ff     <= 1'h0;
      pend_ff     <= 1'h0;
      hold_cnt_ff <= {`CKTM_HOLD_CNT_W{1'b0}};
    end else if (ce_i) begin
      cnt_lo_ff   <= nxt_cnt_lo;
      cnt_hi_ff   <= nxt_cnt_hi;
      hold_ff     <= nxt_hold;
      pend_ff     <= nxt_pend;
      hold_cnt_ff <= nxt_hold_cnt;
    end
  end

  assign tick_count_bits_o = {cnt_hi_ff, cnt_lo_ff};

  // ----------------------------------------------------------------------
  // interrupt flags and request
  // ----------------------------------------------------------------------
  wire [3:0] tick_flag;

  cktm_flags u_flags (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n),
    .ce_i       (ce_i),
    .cnt_now_i  ({cnt_hi_ff, cnt_lo_ff}),
    .cnt_nxt_i  ({nxt_cnt_hi, nxt_cnt_lo}),
    .edge_ok_i  (~count_clear_strobe),
    .clr_wr_i   (wr_flags),
    .clr_mask_i (wdata_i),
    .flags_o    (tick_flag)
  );

  // level request while any enabled flag stands
  assign irq_o = |(tick_flag & tick_enable_ff);

  // ----------------------------------------------------------------------
  // read data, valid in the cycle after the read strobe
  // ----------------------------------------------------------------------
  reg [`CKTM_DATA_W-1:0] rdata_ff;
  reg [`CKTM_DATA_W-1:0] nxt_rdata;

  always @* begin
    nxt_rdata = `CKTM_RDATA_ZERO;
    if (rd_i) begin
      case (addr_i)
        `CKTM_OFS_CTRL:      nxt_rdata = {3'h0, count_run_control_ff};
        `CKTM_OFS_CNT_LO:    nxt_rdata = cnt_lo_ff;
        `CKTM_OFS_CNT_HI:    nxt_rdata = cnt_hi_ff;
        `CKTM_OFS_IRQ_EN:    nxt_rdata = tick_enable_ff;
        `CKTM_OFS_IRQ_FLAGS: nxt_rdata = tick_flag;
        default:             nxt_rdata = `CKTM_RDATA_ZERO;
      endcase
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= `CKTM_RDATA_ZERO;
    end else if (ce_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

endmodule

// ### verification/cktm_top_assertions.sv
// cktm_top_assertions.sv - port checker of the clock timer top.
// assumes: bound to cktm_top, ce_i held high, same HOLD_CYC as the design.
`include "cktm_regs.vh"
module cktm_chk #(
  parameter [16:0] HOLD_CYC = 17'h14
) (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        ce_i,
  input wire logic        lso_prescale_i,
  input wire logic [15:0] addr_i,
  input wire logic [3:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [3:0]  rdata_o,
  input wire logic [7:0]  tick_count_bits_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire         rlo = ce_i && rd_i && addr_i == `CKTM_OFS_CNT_LO;
  wire         rhi = ce_i && rd_i && addr_i == `CKTM_OFS_CNT_HI;
  wire         wct = ce_i && wr_i && addr_i == `CKTM_OFS_CTRL;
  logic [3:0]  lo_inc_ff;
  logic [16:0] hold_ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------------------------------
  // high word hold window as seen from the bus
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lo_inc_ff <= 4'h0;
      hold_ff   <= 17'h0;
    end else begin
      lo_inc_ff <= tick_count_bits_o[3:0] + 4'h1;
      if (rhi || (wct && wdata_i[1]))
        hold_ff <= 17'h0;
      else if (rlo)
        hold_ff <= 17'h1;
      else if (hold_ff != 17'h0 && hold_ff < HOLD_CYC)
        hold_ff <= hold_ff + 17'h1;
      else
        hold_ff <= 17'h0;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_RD_LO: assert property (rlo |=>
    rdata_o == $past(tick_count_bits_o[3:0])) else $error("low read bad");
  AST_RD_HI: assert property (rhi |=>
    rdata_o == $past(tick_count_bits_o[7:4])) else $error("high read bad");
  AST_IDLE_ZERO: assert property (!(ce_i && rd_i) |=>
    rdata_o == 4'h0) else $error("read data not zero when idle");
  AST_LO_STEP: assert property ($changed(tick_count_bits_o[3:0]) |->
    tick_count_bits_o[3:0] == lo_inc_ff || tick_count_bits_o[3:0] == 4'h0)
    else $error("low word jumped");
  AST_CLR: assert property (wct && wdata_i[1] |=>
    tick_count_bits_o == 8'h00) else $error("clear did not zero count");
  AST_STOP: assert property (wct && wdata_i[1:0] == 2'h0 |=>
    ##1 $stable(tick_count_bits_o) [*8]) else $error("count moved stopped");
  AST_HOLD: assert property (hold_ff > 17'h1 &&
    hold_ff < HOLD_CYC - 17'h1 |-> $stable(tick_count_bits_o[7:4]))
    else $error("high word moved during hold");
  AST_MASK0: assert property (ce_i && wr_i && wdata_i == 4'h0 &&
    addr_i == `CKTM_OFS_IRQ_EN |=> !irq_o) else $error("irq with mask off");
  AST_RST: assert property (disable iff (1'b0) !nrst_i |->
    tick_count_bits_o == 8'h00 && !irq_o && rdata_o == 4'h0)
    else $error("outputs not cleared in reset");
endmodule

// ### verification/cktm_presc_src.sv
// cktm_presc_src.sv - stand-in for the slow oscillator prescaler level.
// assumes: one step of the timer every 2*HALF cycles of clk_i.
module cktm_presc_src #(
  parameter int HALF = 4
) (
  input  wire logic clk_i,
  output logic      lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  initial begin
    lvl_o = 1'b0;
    cnt   = 0;
  end
  always @(posedge clk_i) begin
    if (cnt == HALF - 1) begin
      cnt   <= 0;
      lvl_o <= ~lvl_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ### verification/cktm_top_tb.sv
// cktm_top_tb.sv - self-checking bench of the clock timer top.
// assumes: checker and prescaler stand-in compiled before this file.
`include "cktm_regs.vh"
module cktm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] a; logic [3:0] d; logic [3:0] e;} cktm_row_t;
  localparam logic [15:0] RG [5] = '{`CKTM_OFS_CTRL, `CKTM_OFS_CNT_LO,
    `CKTM_OFS_CNT_HI, `CKTM_OFS_IRQ_EN, `CKTM_OFS_IRQ_FLAGS};
  cktm_row_t   rows [9] = '{'{RG[3], 4'hA, 4'hA}, '{RG[3], 4'h5, 4'h5},
    '{RG[1], 4'hF, 4'h0}, '{RG[2], 4'hF, 4'h0}, '{16'hFF00, 4'hF, 4'h0},
    '{RG[4], 4'hF, 4'h0}, '{RG[0], 4'hE, 4'h0}, '{RG[0], 4'h1, 4'h1},
    '{RG[0], 4'h0, 4'h0}};
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [3:0]  wdata_i = 4'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        lso;
  wire  [3:0]  rdata_o;
  wire  [7:0]  cnt;
  wire         irq_o;
  logic [3:0]  v;
  logic [7:0]  held;
  int          err_total = 0;
  int          num_checks = 0;
  initial forever #4 clk_i = ~clk_i;
  cktm_presc_src #(.HALF(4)) src (.clk_i(clk_i), .lvl_o(lso));
  cktm_top #(.HOLD_CYC(17'h14)) uut (.clk_i(clk_i), .nrst_i(nrst_i),
    .ce_i(1'b1), .lso_prescale_i(lso), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tick_count_bits_o(cnt),
    .irq_o(irq_o));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // waits until the masked {irq, count} matches, within lim cycles
  task automatic waitv(input logic [8:0] m, input logic [8:0] x, int lim);
    int n = 0;
    while ((({irq_o, cnt} & m) !== x) && n < lim) begin
      @(posedge clk_i);
      #1 n++;
    end
    if ((({irq_o, cnt} & m) !== x)) begin
      err_total++;
      $display("BAD %0t wait ran out", $time);
      close_out();
    end
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    // a real falling edge, so the asynchronous reset acts from time zero
    nrst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(cnt, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rd(RG[i]);
      chk(v, 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(v, rows[i].e);
    end
    held = cnt;
    repeat (40) @(posedge clk_i);
    chk(cnt, held);
    wr(RG[0], 4'h1);
    waitv(9'h0FF, {1'b0, held + 8'h01}, 30);
    wr(RG[0], 4'h3);
    waitv(9'h0FF, 9'h00F, 300);
    rd(RG[1]);
    chk(v, 8'h0F);
    waitv(9'h00F, 9'h000, 30);
    chk(cnt, 8'h00);
    rd(RG[2]);
    chk(v, 8'h00);
    chk(cnt[7:4], 8'h01);
    waitv(9'h0FF, 9'h01F, 300);
    rd(RG[1]);
    waitv(9'h00F, 9'h000, 30);
    chk(cnt, 8'h10);
    waitv(9'h0F0, 9'h020, 30);
    wr(RG[4], 4'hF);
    wr(RG[3], 4'h1);
    waitv(9'h100, 9'h100, 200);
    rd(RG[4]);
    chk(v[0], 8'h01);
    wr(RG[3], 4'h0);
    #1 chk(irq_o, 8'h00);
    wr(RG[4], 4'hF);
    waitv(9'h080, 9'h080, 2100);
    waitv(9'h080, 9'h000, 2100);
    repeat (2) @(posedge clk_i);
    rd(RG[4]);
    chk(v, 8'h0F);
    chk(irq_o, 8'h00);
    wr(RG[4], 4'h5);
    rd(RG[4]);
    chk(v, 8'h0A);
    wr(RG[3], 4'hF);
    wr(RG[0], 4'h3);
    #1 chk(cnt, 8'h00);
    waitv(9'h0FF, 9'h001, 30);
    nrst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk(cnt, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(RG[0]);
    chk(v, 8'h00);
    close_out();
  end
endmodule
bind cktm_top cktm_chk #(.HOLD_CYC(HOLD_CYC)) chk_u (.clk_i(clk_i),
  .nrst_i(nrst_i), .ce_i(ce_i), .lso_prescale_i(lso_prescale_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .tick_count_bits_o(tick_count_bits_o), .irq_o(irq_o));
